// file: src/status_word_pkg.sv
`default_nettype none
package status_word_pkg;

  // ************************************************************
  // Register map and field positions.
  // ************************************************************
  localparam logic [7:0] WORD_OFFSET     = 8'hd0;
  localparam logic [7:0] WORD_RESET      = 8'h00;
  localparam int         CARRY_BIT       = 7;
  localparam int         AUX_BIT         = 6;
  localparam int         USER_A_BIT      = 5;
  localparam int         BANK_HI_BIT     = 4;
  localparam int         BANK_LO_BIT     = 3;
  localparam int         OVERFLOW_BIT    = 2;
  localparam int         USER_B_BIT      = 1;
  localparam int         PARITY_BIT      = 0;
  localparam logic [7:0] BANK_SIZE_BYTES = 8'h08;
  localparam logic [7:0] PRODUCT_LIMIT   = 8'hff;

  // ************************************************************
  // Carriers.
  // ************************************************************
  typedef struct packed {
    logic       arith_valid;
    logic       carry_out;
    logic       aux_carry;
    logic       arith_ovf;
    logic       mul_valid;
    logic [15:0] product;
  } alu_flags_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

endpackage
`default_nettype wire

// file: src/parity_unit.sv
`timescale 1ns/1ps
`default_nettype none
module parity_unit (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] accumulator_reg,
  output var  logic       parity_reg
);
  logic parity_next;

  always_comb begin
    parity_next = ^accumulator_reg;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      parity_reg <= 1'b0;
    end else begin
      parity_reg <= parity_next;
    end
  end
endmodule // parity_unit
`default_nettype wire

// file: src/cpu_status_flag_register.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_status_flag_register (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic [7:0]                 addr,
  input  wire logic [7:0]                 wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  input  wire logic [7:0]                 accumulator_reg,
  input  wire status_word_pkg::alu_flags_t alu,
  output var  logic [7:0]                 rdata,
  output var  logic [7:0]                 program_status_word,
  output var  logic [1:0]                 bank_sel,
  output var  logic [7:0]                 bank_base
);

  // ************************************************************
  // State.
  // ************************************************************
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] rdata_next;
  logic [7:0] base_next;
  logic       parity_bit;
  logic       word_hit;

  // ************************************************************
  // Helpers.
  // ************************************************************
  // The two bank bits sit side by side in the word (bits 4 and 3) and are gathered in one place.
  function automatic logic [1:0] bank_of(input logic [7:0] word);
    bank_of = {word[status_word_pkg::BANK_HI_BIT], word[status_word_pkg::BANK_LO_BIT]};
  endfunction

  // bank base address.
  // The product never exceeds 8'h18, so the cast to eight bits loses nothing.
  function automatic logic [7:0] base_of(input logic [1:0] bank);
    base_of = 8'({6'h00, bank} * status_word_pkg::BANK_SIZE_BYTES);
  endfunction

  parity_unit u_parity (
    .mclk            (mclk),
    .rst             (rst),
    .accumulator_reg (accumulator_reg),
    .parity_reg      (parity_bit)
  );

  assign word_hit = (addr == status_word_pkg::WORD_OFFSET);

  // ************************************************************
  // Flag update.
  // ************************************************************
  // ALU results are applied after a software write in the same cycle, since the instruction outcome is newer.
  always_comb begin
    flags_next = flags_reg;
    if (wr && word_hit) begin
      flags_next = wdata;
    end
    if (alu.arith_valid) begin
      flags_next[status_word_pkg::CARRY_BIT] = alu.carry_out;
      flags_next[status_word_pkg::AUX_BIT] = alu.aux_carry;
      flags_next[status_word_pkg::OVERFLOW_BIT] = alu.arith_ovf;
    end
    if (alu.mul_valid) begin
      flags_next[status_word_pkg::OVERFLOW_BIT] = (alu.product[15:8] != 8'h00);
    end
    flags_next[status_word_pkg::PARITY_BIT] = 1'b0;
  end

  always_comb begin
    base_next = base_of(bank_of(flags_next));
    rdata_next = 8'h00;
    // Reads of any other address return zero so that a shared read bus can be ored.
    if (rd && word_hit) begin
      rdata_next = flags_reg | {7'h00, parity_bit};
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_reg <= status_word_pkg::WORD_RESET;
      rdata     <= 8'h00;
      bank_base <= 8'h00;
      bank_sel  <= 2'h0;
      program_status_word <= 8'h00;
    end else begin
      flags_reg <= flags_next;
      rdata     <= rdata_next;
      bank_base <= base_next;
      bank_sel  <= bank_of(flags_next);
      program_status_word <= flags_next | {7'h00, ^accumulator_reg};
    end
  end

  // ************************************************************
  // Checks.
  // ************************************************************
  mul_ovf_a : assert property (@(posedge mclk) disable iff (rst)
    alu.mul_valid |=> flags_reg[status_word_pkg::OVERFLOW_BIT] == ($past(alu.product) > 16'h00ff))
    else $error("overflow wrong after multiply");
  aux_carry_a : assert property (@(posedge mclk) disable iff (rst)
    alu.arith_valid |=> flags_reg[status_word_pkg::AUX_BIT] == $past(alu.aux_carry))
    else $error("aux carry wrong");
  main_carry_a : assert property (@(posedge mclk) disable iff (rst)
    alu.arith_valid |=> flags_reg[status_word_pkg::CARRY_BIT] == $past(alu.carry_out))
    else $error("main carry wrong");
  bank_base_a : assert property (@(posedge mclk) disable iff (rst)
    bank_base == {3'h0, bank_sel, 3'h0} && bank_base <= 8'h18)
    else $error("bank base wrong");
  parity_a : assert property (@(posedge mclk) disable iff (rst)
    ##1 program_status_word[0] == ^$past(accumulator_reg))
    else $error("parity wrong");

  // software write of the user flags.
  // Only checked without an ALU pulse, because the ALU may own other bits then.
  user_flags_a : assert property (@(posedge mclk) disable iff (rst)
    (wr && word_hit && !alu.arith_valid && !alu.mul_valid)
    |=> (flags_reg[status_word_pkg::USER_A_BIT] == $past(wdata[status_word_pkg::USER_A_BIT]))
    && (flags_reg[status_word_pkg::USER_B_BIT] == $past(wdata[status_word_pkg::USER_B_BIT])))
    else $error("user flag write lost");

  // software write of the bank select.
  bank_write_a : assert property (@(posedge mclk) disable iff (rst)
    (wr && word_hit)
    |=> bank_sel == {$past(wdata[status_word_pkg::BANK_HI_BIT]), $past(wdata[status_word_pkg::BANK_LO_BIT])})
    else $error("bank select write lost");

  // the live word and the bank outputs agree.
  word_bank_a : assert property (@(posedge mclk) disable iff (rst)
    {program_status_word[status_word_pkg::BANK_HI_BIT], program_status_word[status_word_pkg::BANK_LO_BIT]}
    == bank_sel)
    else $error("bank select and word disagree");

  arith_ovf_a : assert property (@(posedge mclk) disable iff (rst)
    (alu.arith_valid && !alu.mul_valid)
    |=> flags_reg[status_word_pkg::OVERFLOW_BIT] == $past(alu.arith_ovf))
    else $error("arithmetic overflow wrong");

  // a multiply touches only overflow, so the main carry is kept.
  mul_carry_a : assert property (@(posedge mclk) disable iff (rst)
    (alu.mul_valid && !alu.arith_valid && !(wr && word_hit))
    |=> flags_reg[status_word_pkg::CARRY_BIT] == $past(flags_reg[status_word_pkg::CARRY_BIT]))
    else $error("carry changed by multiply");

  // stored flags hold while nothing writes them.
  flags_hold_a : assert property (@(posedge mclk) disable iff (rst)
    (!(wr && word_hit) && !alu.arith_valid && !alu.mul_valid)
    |=> flags_reg == $past(flags_reg))
    else $error("flags changed without cause");

  // the stored parity bit stays clear; parity is merged on the way out.
  parity_store_a : assert property (@(posedge mclk) disable iff (rst)
    flags_reg[status_word_pkg::PARITY_BIT] == 1'b0)
    else $error("stored parity bit set");

  // read data carry the stored flags and the parity register.
  read_word_a : assert property (@(posedge mclk) disable iff (rst)
    (rd && word_hit)
    |=> (rdata[7:1] == $past(flags_reg[7:1])) && (rdata[0] == $past(parity_bit)))
    else $error("read data wrong");

  // read data stand for one cycle only and are zero otherwise.
  read_idle_a : assert property (@(posedge mclk) disable iff (rst)
    !(rd && word_hit) |=> rdata == 8'h00)
    else $error("read data not idle");

  // the live word shows the aux carry one cycle after the pulse.
  word_aux_a : assert property (@(posedge mclk) disable iff (rst)
    alu.arith_valid |=> program_status_word[status_word_pkg::AUX_BIT] == $past(alu.aux_carry))
    else $error("word aux carry wrong");

  // the live word shows the main carry one cycle after the pulse.
  word_carry_a : assert property (@(posedge mclk) disable iff (rst)
    alu.arith_valid |=> program_status_word[status_word_pkg::CARRY_BIT] == $past(alu.carry_out))
    else $error("word main carry wrong");

endmodule // cpu_status_flag_register
`default_nettype wire

// file: verif/cpu_status_flag_register_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_status_flag_register_tb;
  logic                        mclk, rst, wr, rd;
  logic [7:0]                  addr, wdata, acc, rdata, word_out, base, mp, m, e;
  logic [1:0]                  bsel;
  logic [31:0]                 r;
  status_word_pkg::alu_flags_t alu;
  int                          n_fail, tests_run, seed;
  cpu_status_flag_register u_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .accumulator_reg(acc), .alu(alu), .rdata(rdata), .program_status_word(word_out), .bank_sel(bsel),
    .bank_base(base));
  task chk(input logic [7:0] s, input logic [7:0] x);
    tests_run++;
    if (s !== x) begin
      n_fail++;
      $display("mismatch %0t %h %h", $time, s, x);
    end
  endtask
  task stop_test;
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    #20000;
    n_fail++;
    stop_test;
  end
  // ****
  // Random mix of writes, ALU pulses and reads.
  // ****
  // The mask drops the carry bits after a multiply, since only overflow is defined for it.
  initial begin
    seed = 32'h5d1f;
    {rst, wr, rd, addr, wdata, acc, alu, mp} = '0;
    rst = 1;
    m = 8'hff;
    repeat (10) @(posedge mclk);
    rst <= 0;
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      @(posedge mclk);
      acc <= r[31:24];
      wr <= !r[1];
      addr <= r[0] ? r[15:8] : 8'hd0;
      wdata <= r[23:16];
      alu.arith_valid <= r[1] & !r[0];
      alu.mul_valid <= r[1] & r[0];
      alu.carry_out <= r[5];
      alu.aux_carry <= r[6];
      alu.arith_ovf <= r[7];
      alu.product <= r[3] ? r[31:16] : (r[2] ? 16'h00ff : 16'h0100);
      if (!r[1] && (!r[0] || r[15:8] == 8'hd0)) begin
        mp = {r[23:17], 1'b0};
        m = 8'hff;
      end
      if (r[1] & !r[0]) begin
        mp[7:6] = {r[5], r[6]};
        mp[2] = r[7];
        m[7:6] = 2'b11;
      end
      if (r[1] & r[0]) begin
        mp[2] = r[3] ? (r[31:16] > 16'h00ff) : !r[2];
        m[7:6] = 2'b00;
      end
      @(posedge mclk);
      wr <= 0;
      alu <= '0;
      rd <= 1;
      addr <= r[4] ? r[15:8] : 8'hd0;
      @(posedge mclk);
      rd <= 0;
      #1;
      e = {mp[7:1], ^acc} & m;
      chk(rdata & m, (r[4] && r[15:8] != 8'hd0) ? 8'h00 : e);
      chk(word_out & m, e);
      chk({6'h00, bsel}, {6'h00, mp[4:3]});
      chk(base, {3'h0, mp[4:3], 3'h0});
      @(posedge mclk);
      #1;
      chk(rdata, 8'h00);
    end
    stop_test;
  end
endmodule // cpu_status_flag_register_tb
`default_nettype wire
